// File: shared/smbus_pkg.sv
// package: register map, field positions, reset values and counts
package smbus_pkg;
  // ***********************
  // register offsets (apb byte addresses)
  // ***********************
  localparam logic [7:0] cfg_off = 8'h00;
  localparam logic [7:0] ctl_off = 8'h04;
  localparam logic [7:0] dat_off = 8'h08;
  // ***********************
  // config fields
  // ***********************
  localparam int cfg_sel_lo = 0;
  localparam int cfg_sel_hi = 1;
  localparam int cfg_free_en = 2;
  localparam int cfg_tmo_en = 3;
  localparam int cfg_split = 4;
  localparam logic [7:0] cfg_reset = 8'h00;
  // ***********************
  // control fields
  // ***********************
  localparam int ctl_irq = 0;
  localparam int ctl_ack = 1;
  localparam int ctl_arb = 2;
  localparam int ctl_ack_need = 3;
  localparam int ctl_halt = 4;
  localparam int ctl_begin = 5;
  localparam int ctl_tx = 6;
  localparam int ctl_mst = 7;
  localparam logic [7:0] ctl_reset = 8'h00;
  // bus free after more than this many source periods
  localparam logic [3:0] free_periods = 4'ha;
  // bit rate source encodings
  localparam logic [1:0] src_t0 = 2'h0;
  localparam logic [1:0] src_t1 = 2'h1;
  localparam logic [1:0] src_t2h = 2'h2;
  localparam logic [1:0] src_t2l = 2'h3;
  // suggested scl low timeout for software
  localparam int scl_low_tmo_ms = 25;
  localparam int clk_mhz = 125;
  localparam longint scl_low_tmo_cycles =
    longint'(scl_low_tmo_ms) * 1000 * clk_mhz;
  typedef enum logic [2:0] {
    st_idle, st_start, st_bits, st_ack, st_stop, st_wait
  } bit_state_e;
endpackage

// File: shared/smbus_line_if.sv
// interface: synchronised line levels and edge events
`timescale 1ns/1ns
interface smbus_line_if;
  logic sda;
  logic scl;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  modport mon (output sda, scl, start_seen, stop_seen, scl_rise, scl_fall);
  modport core (input sda, scl, start_seen, stop_seen, scl_rise, scl_fall);
endinterface

// File: rtl/smbus_line_monitor.sv
// line synchroniser and start/stop/edge detector
`timescale 1ns/1ns
module smbus_line_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic sda_in,
  input wire logic scl_in,
  smbus_line_if.mon lines
);
  logic [1:0] sda_sync_q;
  logic [1:0] scl_sync_q;
  logic sda_prev_q;
  logic scl_prev_q;

  // two stages; only the second stage is looked at
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
      sda_prev_q <= 1'b1;
      scl_prev_q <= 1'b1;
    end else begin
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_prev_q <= sda_sync_q[1];
      scl_prev_q <= scl_sync_q[1];
    end
  end

  // start: sda falls while scl high; stop: sda rises while scl high
  assign lines.sda = sda_sync_q[1];
  assign lines.scl = scl_sync_q[1];
  assign lines.start_seen = sda_prev_q & ~sda_sync_q[1] & scl_sync_q[1] &
    scl_prev_q;
  assign lines.stop_seen = ~sda_prev_q & sda_sync_q[1] & scl_sync_q[1] &
    scl_prev_q;
  assign lines.scl_rise = ~scl_prev_q & scl_sync_q[1];
  assign lines.scl_fall = scl_prev_q & ~scl_sync_q[1];
endmodule

// File: rtl/smbus_control_and_status.sv
// smbus control and status core with apb registers
// Summary of operation
// - scl high holds timer 2 reload, high byte only when split
// - both lines high over ten periods: free
// - free timeout acts like stop
// - low config bits pick bit rate source
// - upper control nibble is status vector
// - master and transmitter flags report state
// - start flag shows start since interrupt
// - writing start on a free bus enters master, starts when free
// - start flag stays until software clears
// - master stop after ack, then cleared
// - slave stop flag reports observed stop
// - start and stop both: stop then start
// - ack bit: send value or received value
// - acknowledge needed set after byte received
// - interrupt cleared without ack write sends nack
// - sda follows ack write, scl low till clear
// - nacked address ignores slave events till start
// - arbitration failed on loss while transmitting
// - clearing interrupt clears arbitration failed
// - interrupt at master start, end, byte, loss
// - interrupt set stalls, scl held low
`timescale 1ns/1ns
module smbus_control_and_status (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_hi_ovf,
  input wire logic timer2_lo_ovf,
  output logic timer2_hi_reload,
  output logic timer2_lo_reload,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe
);
  // ***********************
  // line monitor
  // ***********************
  smbus_line_if lines ();
  smbus_line_monitor u_mon (
    .clk(clk),
    .rst(rst),
    .sda_in(sda_in),
    .scl_in(scl_in),
    .lines(lines)
  );

  // ***********************
  // registers
  // ***********************
  logic [7:0] cfg_q;
  // status flags of the control register
  logic mst_q, tx_q, begin_req_q, halt_req_q, ack_need_q, arb_q, ack_q, irq_q;
  logic ack_written_q;
  logic [7:0] shift_q;
  logic [7:0] rx_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] free_cnt_q;
  logic bus_busy_q;
  logic ignore_q;
  logic addr_phase_q;
  logic sda_drive_q;
  logic tick_q;
  logic tick_phase_q;
  smbus_pkg::bit_state_e state_q;

  logic wr, wr_cfg, wr_ctl, wr_dat, irq_clear, src_ovf;
  logic sda_low_req;

  assign wr = psel & penable & pwrite;
  assign wr_cfg = wr & (paddr == smbus_pkg::cfg_off);
  assign wr_ctl = wr & (paddr == smbus_pkg::ctl_off);
  assign wr_dat = wr & (paddr == smbus_pkg::dat_off);
  assign irq_clear = wr_ctl & irq_q & ~pwdata[smbus_pkg::ctl_irq];
  // zero wait states: registers are plain flops, nothing to wait for
  // a write therefore lands at the edge that ends the access phase
  assign pready = 1'b1;

  // unmapped addresses raise pslverr in the access phase
  assign pslverr = psel & penable & (paddr != smbus_pkg::cfg_off) &
    (paddr != smbus_pkg::ctl_off) & (paddr != smbus_pkg::dat_off);

  // read data is a combinational mux of flip-flop state, not registered
  always_comb begin
    prdata = 32'h0;
    case (paddr)
      smbus_pkg::cfg_off: prdata = {24'h0, cfg_q};
      // upper nibble is the status vector for software dispatch
      smbus_pkg::ctl_off: prdata = {24'h0, mst_q, tx_q, begin_req_q,
        halt_req_q, ack_need_q, arb_q, ack_q, irq_q};
      smbus_pkg::dat_off: prdata = {24'h0, rx_q};
      default: prdata = 32'h0;
    endcase
  end

  // config register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cfg_q <= smbus_pkg::cfg_reset;
    else if (wr_cfg) cfg_q <= pwdata[7:0];
  end

  // ***********************
  // bit rate source and timer 2 coupling
  // ***********************
  // select field picks the overflow used as bit rate tick
  always_comb begin
    case (cfg_q[smbus_pkg::cfg_sel_hi:smbus_pkg::cfg_sel_lo])
      smbus_pkg::src_t0: src_ovf = timer0_ovf;
      smbus_pkg::src_t1: src_ovf = timer1_ovf;
      smbus_pkg::src_t2h: src_ovf = timer2_hi_ovf;
      smbus_pkg::src_t2l: src_ovf = timer2_lo_ovf;
      default: src_ovf = 1'b0;
    endcase
  end

  // split mode only holds the high byte while scl high
  assign timer2_hi_reload = cfg_q[smbus_pkg::cfg_tmo_en] & lines.scl;
  assign timer2_lo_reload = cfg_q[smbus_pkg::cfg_tmo_en] & lines.scl &
    ~cfg_q[smbus_pkg::cfg_split];

  // each overflow toggles a phase; one tick per half bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
      tick_phase_q <= 1'b0;
    end else begin
      tick_q <= src_ovf;
      if (src_ovf) tick_phase_q <= ~tick_phase_q;
    end
  end

  // ***********************
  // bus busy and free timeout
  // ***********************
  logic free_timeout;
  assign free_timeout = cfg_q[smbus_pkg::cfg_free_en] & bus_busy_q &
    lines.sda & lines.scl & tick_q &
    (free_cnt_q == smbus_pkg::free_periods);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      free_cnt_q <= 4'h0;
      bus_busy_q <= 1'b0;
    end else begin
      if (!(lines.sda & lines.scl)) free_cnt_q <= 4'h0;
      else if (tick_q && free_cnt_q != smbus_pkg::free_periods)
        free_cnt_q <= free_cnt_q + 4'h1;
      if (lines.start_seen) bus_busy_q <= 1'b1;
      else if (lines.stop_seen || free_timeout) bus_busy_q <= 1'b0;
    end
  end

  // ***********************
  // bit engine
  // ***********************
  logic byte_done, ack_done, lost, stop_done, start_done;
  assign byte_done = (state_q == smbus_pkg::st_bits) & ~irq_q &
    lines.scl_fall & (bit_cnt_q == 4'h7);
  assign lost = tx_q & sda_drive_q & ~lines.sda & lines.scl_rise &
    (state_q == smbus_pkg::st_bits);
  assign start_done = (state_q == smbus_pkg::st_start) & tick_q &
    ~lines.sda;
  assign stop_done = (state_q == smbus_pkg::st_stop) & tick_q &
    lines.sda & lines.scl;
  assign ack_done = (state_q == smbus_pkg::st_ack) & lines.scl_fall;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= smbus_pkg::st_idle;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h0;
      rx_q <= 8'h0;
      addr_phase_q <= 1'b0;
    end else begin
      case (state_q)
        smbus_pkg::st_idle: begin
          // start request waits for a free bus
          // taken only with the flag clear, so software sees each event
          if (begin_req_q && !bus_busy_q && !irq_q) begin
            state_q <= smbus_pkg::st_start;
          end else if (lines.start_seen) begin
            state_q <= smbus_pkg::st_bits;
            bit_cnt_q <= 4'h0;
            addr_phase_q <= 1'b1;
          end
        end
        smbus_pkg::st_start: begin
          if (start_done) begin
            state_q <= smbus_pkg::st_bits;
            bit_cnt_q <= 4'h0;
            addr_phase_q <= 1'b1;
          end
        end
        smbus_pkg::st_bits: begin
          if (lost) state_q <= smbus_pkg::st_idle;
          else if (lines.scl_rise) shift_q <= {shift_q[6:0], lines.sda};
          if (wr_dat) shift_q <= pwdata[7:0];
          if (!irq_q && lines.scl_fall) begin
            if (bit_cnt_q == 4'h7) begin
              state_q <= smbus_pkg::st_ack;
              rx_q <= shift_q;
            end
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        smbus_pkg::st_ack: begin
          if (ack_done) begin
            addr_phase_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            // stop request ends the transfer after this ack
            // a pending start after the ack gives a repeated start
            if (mst_q && halt_req_q) state_q <= smbus_pkg::st_stop;
            else if (mst_q && begin_req_q) state_q <= smbus_pkg::st_start;
            else state_q <= smbus_pkg::st_bits;
          end
        end
        smbus_pkg::st_stop: begin
          // repeated start follows stop when both flags set
          if (stop_done) begin
            // the start waits until software has seen the stop
            if (begin_req_q) state_q <= smbus_pkg::st_wait;
            else state_q <= smbus_pkg::st_idle;
          end
        end
        smbus_pkg::st_wait: if (!irq_q) state_q <= smbus_pkg::st_idle;
        default: state_q <= smbus_pkg::st_idle;
      endcase
      // a free timeout ends a hung frame just as a stop would
      if ((lines.stop_seen && state_q != smbus_pkg::st_stop) ||
        free_timeout)
        state_q <= smbus_pkg::st_idle;
    end
  end

  // ***********************
  // control register
  // ***********************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mst_q <= 1'b0;
      tx_q <= 1'b0;
      begin_req_q <= 1'b0;
      halt_req_q <= 1'b0;
      ack_need_q <= 1'b0;
      arb_q <= 1'b0;
      ack_q <= 1'b0;
      irq_q <= 1'b0;
      ack_written_q <= 1'b0;
      ignore_q <= 1'b0;
    end else begin
      // software writes first; hardware sets below win
      if (wr_ctl) begin
        begin_req_q <= pwdata[smbus_pkg::ctl_begin];
        halt_req_q <= pwdata[smbus_pkg::ctl_halt];
        ack_q <= pwdata[smbus_pkg::ctl_ack];
        ack_written_q <= 1'b1;
        irq_q <= irq_q & pwdata[smbus_pkg::ctl_irq];
      end
      if (irq_clear) begin
        arb_q <= 1'b0;
        ack_need_q <= 1'b0;
        // no ack written since the interrupt: send nack
        if (!wr_ctl || !ack_written_q) ack_q <= 1'b0;
      end
      if (wr_ctl && pwdata[smbus_pkg::ctl_begin] && !bus_busy_q)
        mst_q <= 1'b1;
      if (wr_dat) tx_q <= 1'b1;
      if (start_done) begin
        irq_q <= 1'b1;
        tx_q <= 1'b1;
        ack_written_q <= 1'b0;
        begin_req_q <= 1'b1;
      end
      // a new start also ends the deaf spell after a nacked address
      if (lines.start_seen && !mst_q) begin
        begin_req_q <= 1'b1;
        ignore_q <= 1'b0;
      end
      if (byte_done && !ignore_q) begin
        irq_q <= 1'b1;
        ack_written_q <= 1'b0;
        // only a received byte asks software for an acknowledge value
        if (!tx_q) ack_need_q <= 1'b1;
      end
      if (ack_done) begin
        if (tx_q) ack_q <= ~lines.sda;
        if (!mst_q && addr_phase_q && !ack_q) ignore_q <= 1'b1;
      end
      if (stop_done) begin
        // the master role ends once its own stop is on the bus
        halt_req_q <= 1'b0;
        mst_q <= 1'b0;
        tx_q <= 1'b0;
        irq_q <= 1'b1;
      end
      if ((lines.stop_seen && !mst_q && !ignore_q) || free_timeout) begin
        halt_req_q <= 1'b1;
        irq_q <= 1'b1;
        tx_q <= 1'b0;
      end
      if (lost) begin
        arb_q <= 1'b1;
        irq_q <= 1'b1;
        mst_q <= 1'b0;
      end
    end
  end

  // ***********************
  // line drivers
  // ***********************
  // sda low during start, ack out, data zero, stop setup
  always_comb begin
    case (state_q)
      smbus_pkg::st_start: sda_low_req = tick_phase_q | ~lines.sda;
      smbus_pkg::st_bits: sda_low_req = tx_q & ~shift_q[7];
      smbus_pkg::st_ack: sda_low_req = ~tx_q & ack_q & ~ignore_q;
      smbus_pkg::st_stop: sda_low_req = ~tick_phase_q;
      default: sda_low_req = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) sda_drive_q <= 1'b0;
    else sda_drive_q <= ~sda_low_req;
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_low_req;
  assign scl_out = 1'b0;
  // interrupt stalls the bus by holding scl low
  assign scl_oe = (irq_q & ~lines.scl) |
    (mst_q & (state_q == smbus_pkg::st_bits ||
      state_q == smbus_pkg::st_ack) & ~tick_phase_q);
endmodule

// File: tb/smbus_asserts.sv
// concurrent checks on the smbus control and status ports
`timescale 1ns/1ns
module smbus_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer2_hi_reload,
  input wire logic timer2_lo_reload,
  input wire logic sda_out,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic scl_in
);
  logic [7:0] cfg_q;
  logic mapped;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ***************
  // access shapes
  // ***************
  sequence wr_cfg_s;
    psel && penable && pwrite && paddr == smbus_pkg::cfg_off;
  endsequence
  sequence rd_cfg_s;
    psel && penable && !pwrite && paddr == smbus_pkg::cfg_off;
  endsequence
  sequence clr_irq_s;
    psel && penable && pwrite && paddr == smbus_pkg::ctl_off
      && !pwdata[smbus_pkg::ctl_irq];
  endsequence
  sequence rd_ctl_s;
    psel && penable && !pwrite && paddr == smbus_pkg::ctl_off;
  endsequence
  // decode of the three mapped words
  assign mapped = paddr == smbus_pkg::cfg_off
    || paddr == smbus_pkg::ctl_off || paddr == smbus_pkg::dat_off;
  // config mirror, so reload checks know the enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cfg_q <= smbus_pkg::cfg_reset;
    else if (psel && penable && pwrite && paddr == smbus_pkg::cfg_off)
      cfg_q <= pwdata[7:0];
  end
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access refused");
  open_drain_a: assert property (!sda_out && !scl_out)
    else $error("pin driven high");
  hi_off_a: assert property (!scl_in [*4] |-> !timer2_hi_reload)
    else $error("high reload with clock low");
  lo_off_a: assert property (!scl_in [*4] |-> !timer2_lo_reload)
    else $error("low reload with clock low");
  hi_on_a: assert property (
    cfg_q[smbus_pkg::cfg_tmo_en] && scl_in [*4] |-> timer2_hi_reload)
    else $error("high reload missing with clock high");
  split_lo_a: assert property (
    cfg_q[smbus_pkg::cfg_split] |-> !timer2_lo_reload)
    else $error("low reload held in split mode");
  cfg_back_a: assert property (wr_cfg_s ##3 rd_cfg_s |->
    prdata[4:0] == $past(pwdata[4:0], 3))
    else $error("config readback differs");
  arb_clear_a: assert property (clr_irq_s ##3 rd_ctl_s |->
    !prdata[smbus_pkg::ctl_arb])
    else $error("arbitration flag kept after clear");
  stall_a: assert property (rd_ctl_s ##0 (prdata[smbus_pkg::ctl_irq]
    && prdata[smbus_pkg::ctl_mst]) |-> scl_oe)
    else $error("clock not held while flagged");
endmodule
bind smbus_control_and_status smbus_asserts chk_u (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .timer2_hi_reload, .timer2_lo_reload,
  .sda_out, .scl_out, .scl_oe, .scl_in
);

// File: tb/smbus_far_end.sv
// far-side bus party: open-drain start, stop and release sequences
`timescale 1ns/1ns
module smbus_far_end (
  input wire logic clk,
  output logic sda_pull,
  output logic scl_pull
);
  // lines released at time zero; clock stands still between frames
  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
  end
  // half of the 160 ns link period
  task automatic half();
    repeat (10) @(posedge clk);
  endtask
  // data falls while clock high, then clock low
  task automatic start_cond();
    sda_pull <= 1'b1;
    half();
    scl_pull <= 1'b1;
    half();
  endtask
  // data rises while clock high
  task automatic stop_cond();
    sda_pull <= 1'b1;
    half();
    scl_pull <= 1'b0;
    half();
    sda_pull <= 1'b0;
    half();
  endtask
  // data freed while clock low, so no stop is seen
  task automatic release_lines();
    sda_pull <= 1'b0;
    half();
    scl_pull <= 1'b0;
    half();
  endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the smbus control and status block
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] ovf = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, hi_rl, lo_rl, sda_o, sda_oe, scl_o, scl_oe;
  logic far_sda, far_scl;
  wire sda_w, scl_w;
  logic [8:0] exp_q[$];
  logic [8:0] msk_q[$];
  logic [7:0] v;
  int failures = 0;
  int n_checks = 0;
  // pull-ups: a released line reads high
  assign sda_w = !(sda_oe || far_sda);
  assign scl_w = !(scl_oe || far_scl);
  always #4 clk = ~clk;
  smbus_control_and_status dut_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0_ovf(ovf[0]), .timer1_ovf(ovf[1]), .timer2_hi_ovf(ovf[2]),
    .timer2_lo_ovf(ovf[3]), .timer2_hi_reload(hi_rl),
    .timer2_lo_reload(lo_rl), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe(sda_oe), .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe));
  smbus_far_end far_u (.clk(clk), .sda_pull(far_sda), .scl_pull(far_scl));
  // ***************
  // compare and report
  // ***************
  task automatic cmp_rd(input logic [8:0] e, m, s);
    n_checks++;
    if ((s & m) !== (e & m)) begin
      failures++;
      $display("unexpected read word: expected %h seen %h", e & m, s & m);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, s);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // read results: oldest note against what came back
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1)
      cmp_rd(exp_q.pop_front(), msk_q.pop_front(), {pslverr, prdata[7:0]});
  end
  // apb cycle; idle edge first so strobes never change twice in a step
  task automatic apb(input logic w, input logic [7:0] a, d,
                     input logic [8:0] e, m);
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d, 9'h0, 9'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e, m);
    apb(1'b0, a, 8'h00, e, m);
  endtask
  // n one-cycle overflow pulses on timer k
  task automatic tick(input int k, n);
    repeat (n) begin
      @(posedge clk);
      ovf[k] <= 1'b1;
      @(posedge clk);
      ovf[k] <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // ***************
  // scenarios
  // ***************
  initial begin
    v = 8'($urandom(32'he393d29c));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(smbus_pkg::cfg_off, {1'b0, smbus_pkg::cfg_reset}, 9'h1ff);
    rd(smbus_pkg::ctl_off, {1'b0, smbus_pkg::ctl_reset}, 9'h1ff);
    // every source code, random enable bits beside it
    for (int s = 0; s < 4; s++) begin
      v = (8'($urandom()) & 8'h1c) | 8'(s);
      wr(smbus_pkg::cfg_off, v);
      rd(smbus_pkg::cfg_off, {1'b0, v}, 9'h01f);
    end
    // unmapped word refused and without effect
    wr(8'h0c, 8'hff);
    rd(8'h0c, 9'h100, 9'h100);
    rd(smbus_pkg::cfg_off, {1'b0, v}, 9'h01f);
    // timer 2 reload follows the clock line
    wr(smbus_pkg::cfg_off, 8'h08);
    repeat (4) @(posedge clk);
    cmp_bit("high reload", 1'b1, hi_rl);
    cmp_bit("low reload", 1'b1, lo_rl);
    wr(smbus_pkg::cfg_off, 8'h18);
    repeat (2) @(posedge clk);
    cmp_bit("split low reload", 1'b0, lo_rl);
    far_u.start_cond();
    cmp_bit("high reload", 1'b0, hi_rl);
    rd(smbus_pkg::ctl_off, 9'h020, 9'h020);
    wr(smbus_pkg::ctl_off, 8'h00);
    far_u.stop_cond();
    rd(smbus_pkg::ctl_off, 9'h010, 9'h010);
    // busy bus left idle: only the chosen source counts to ten
    far_u.start_cond();
    far_u.release_lines();
    wr(smbus_pkg::ctl_off, 8'h00);
    wr(smbus_pkg::cfg_off, 8'h07);
    tick(0, 12);
    rd(smbus_pkg::ctl_off, 9'h000, 9'h001);
    tick(3, 9);
    rd(smbus_pkg::ctl_off, 9'h000, 9'h001);
    tick(3, 3);
    rd(smbus_pkg::ctl_off, 9'h011, 9'h011);
    // master start on the freed bus, then the stall
    wr(smbus_pkg::ctl_off, 8'h00);
    wr(smbus_pkg::cfg_off, 8'h00);
    wr(smbus_pkg::ctl_off, 8'h20);
    for (int i = 0; i < 300 && scl_oe !== 1'b1; i++)
      tick(0, 1);
    cmp_bit("data pulled", 1'b1, sda_oe);
    rd(smbus_pkg::ctl_off, 9'h0a1, 9'h0a1);
    tick(0, 5);
    cmp_bit("clock held", 1'b1, scl_oe);
    wr(smbus_pkg::ctl_off, 8'h00);
    rd(smbus_pkg::ctl_off, 9'h000, 9'h004);
    report_and_stop();
  end
  // hang guard, far beyond the few hundred cycles of the run
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule
